/* common/hscd_pkg.sv */
package hscd_pkg;
	localparam logic [4:0] REQ_ONE_SPECIAL    = 5'h08;
	localparam logic [2:0] REQ_TWO_SPECIAL    = 3'h1;
	localparam logic [7:0] TYPE_NOP           = 8'h00;
	localparam logic [7:0] TYPE_SHUTDOWN      = 8'h01;
	localparam logic [7:0] TYPE_FLUSH         = 8'h02;
	localparam logic [7:0] TYPE_HALT          = 8'h03;
	localparam logic [7:0] TYPE_SYNC          = 8'h04;
	localparam logic [7:0] TYPE_FLUSH_ACK     = 8'h05;
	localparam logic [7:0] TYPE_STOP_CLK_ACK  = 8'h06;
	localparam logic [7:0] TYPE_MGMT_ACK      = 8'h07;
	localparam logic [1:0] HUB_SHUTDOWN       = 2'h1;
	localparam logic [1:0] HUB_HALT           = 2'h2;
	localparam logic [1:0] HUB_STOP_GRANT     = 2'h3;
	localparam logic [1:0] HUB_NONE           = 2'h0;
	localparam int         ADDR_W             = 33;

	typedef enum logic [1:0] {
		HSCD_IDLE    = 2'b00,
		HSCD_HUB_REQ = 2'b01,
		HSCD_HUB_WAIT= 2'b10,
		HSCD_RETIRE  = 2'b11
	} hscd_state_t;
endpackage

/* common/hscd_if.sv */
interface hscd_if (
	input wire logic clock_in,
	input wire logic reset_n_in
);
	import hscd_pkg::*;
	logic                request_valid;
	logic [4:0]          request_phase_one_code;
	logic [4:0]          request_phase_two_code;
	logic [ADDR_W-1:0]   first_address_phase_lines;
	logic [7:0]          byte_enable_lines;
	logic                management_space_flag;
	logic                request_claimed;
	logic                request_retired;

	modport device (
		input  request_valid, request_phase_one_code, request_phase_two_code,
		input  first_address_phase_lines, byte_enable_lines, management_space_flag,
		output request_claimed, request_retired
	);
	modport processor (
		output request_valid, request_phase_one_code, request_phase_two_code,
		output first_address_phase_lines, byte_enable_lines, management_space_flag,
		input  request_claimed, request_retired
	);
endinterface

/* hw/hscd_type_decode.sv */
module hscd_type_decode (
	input  wire logic [4:0] request_phase_one_code_in,
	input  wire logic [4:0] request_phase_two_code_in,
	input  wire logic [7:0] cycle_type_byte_in,
	output logic            is_special_out,
	output logic [1:0]      hub_code_out,
	output logic            is_mgmt_ack_out
);
	import hscd_pkg::*;

	always_comb begin
		// upper two bits of phase two are don't care [RQ1]
		is_special_out = (request_phase_one_code_in == REQ_ONE_SPECIAL) &&
			(request_phase_two_code_in[2:0] == REQ_TWO_SPECIAL);
		is_mgmt_ack_out = (cycle_type_byte_in == TYPE_MGMT_ACK);
		case (cycle_type_byte_in) // [RQ3]
			TYPE_SHUTDOWN: hub_code_out = HUB_SHUTDOWN; // [RQ5]
			TYPE_HALT: hub_code_out = HUB_HALT; // [RQ7]
			TYPE_STOP_CLK_ACK: hub_code_out = HUB_STOP_GRANT; // [RQ10]
			// nop, flush, sync, flush ack, mgmt ack, reserved stay local
			default: hub_code_out = HUB_NONE; // [RQ4] [RQ6] [RQ8] [RQ9] [RQ12] [RQ15]
		endcase
	end
endmodule

/* hw/hscd_device.sv */
// How it works
// [RQ1] special cycle: phase codes 01000 and xx001
// [RQ2] first address phase ignored on special cycles
// [RQ3] type decoded from the byte enable lines
// [RQ4] nop retires with no side effect
// [RQ5] shutdown forwarded, retired after hub master abort
// [RQ6] flush retired locally
// [RQ7] halt forwarded, retired after hub master abort
// [RQ8] sync retired locally
// [RQ9] flush acknowledge retired locally
// [RQ10] stop clock ack forwarded as stop grant
// [RQ11] mgmt ack with flag set opens space
// [RQ12] mgmt ack never forwarded to hub
// [RQ13] later flagged transactions hit protected space
// [RQ14] mgmt ack with flag clear closes space
// [RQ15] undefined types retired locally, no effect
module hscd_device (
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	hscd_if.device           cpu,
	output logic             hub_cycle_valid_out,
	output logic [1:0]       hub_cycle_code_out,
	input  wire logic        hub_master_abort_in,
	output logic             mgmt_space_open_out,
	output logic             mgmt_space_access_out
);
	import hscd_pkg::*;

	hscd_state_t state_ff;
	hscd_state_t nxt_state;
	logic        is_special;
	logic        is_mgmt_ack;
	logic [1:0]  hub_code;
	logic [1:0]  hub_code_ff;
	logic        take;

	// address phase one is deliberately left unread [RQ2]
	hscd_type_decode u_decode (
		.request_phase_one_code_in (cpu.request_phase_one_code),
		.request_phase_two_code_in (cpu.request_phase_two_code),
		.cycle_type_byte_in        (cpu.byte_enable_lines),
		.is_special_out            (is_special),
		.hub_code_out              (hub_code),
		.is_mgmt_ack_out           (is_mgmt_ack)
	);

	assign take = (state_ff == HSCD_IDLE) && cpu.request_valid && is_special;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			HSCD_IDLE: begin
				if (take)
					nxt_state = (hub_code != HUB_NONE) ? HSCD_HUB_REQ : HSCD_RETIRE;
			end
			HSCD_HUB_REQ: nxt_state = HSCD_HUB_WAIT;
			HSCD_HUB_WAIT: begin
				if (hub_master_abort_in)
					nxt_state = HSCD_RETIRE; // [RQ5] [RQ7] [RQ10]
			end
			HSCD_RETIRE: nxt_state = HSCD_IDLE;
			default: nxt_state = HSCD_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			state_ff <= HSCD_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			hub_code_ff <= HUB_NONE;
		else if (take)
			hub_code_ff <= hub_code;
	end

	// hub request held until the abort comes back
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			hub_cycle_valid_out <= 1'b0;
			hub_cycle_code_out  <= HUB_NONE;
		end else begin
			hub_cycle_valid_out <= (nxt_state == HSCD_HUB_REQ) || (nxt_state == HSCD_HUB_WAIT);
			hub_cycle_code_out  <= (nxt_state == HSCD_IDLE) ? HUB_NONE :
				(take ? hub_code : hub_code_ff);
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cpu.request_claimed <= 1'b0;
			cpu.request_retired <= 1'b0;
		end else begin
			cpu.request_claimed <= take;
			cpu.request_retired <= (nxt_state == HSCD_RETIRE);
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			mgmt_space_open_out <= 1'b0;
		else if (take && is_mgmt_ack)
			mgmt_space_open_out <= cpu.management_space_flag; // [RQ11] [RQ14]
	end

	// non-special transactions only; registered, so one cycle late
	always_ff @(posedge clock_in) begin
		if (!reset_n_in)
			mgmt_space_access_out <= 1'b0;
		else
			mgmt_space_access_out <= mgmt_space_open_out && cpu.request_valid &&
				!is_special && cpu.management_space_flag; // [RQ13]
	end
endmodule

/* hw/hscd_processor.sv */
module hscd_processor (
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	hscd_if.processor        cpu,
	input  wire logic        issue_in,
	input  wire logic        issue_special_in,
	input  wire logic [7:0]  issue_type_in,
	input  wire logic        issue_flag_in,
	output logic             busy_out,
	output logic             done_out
);
	import hscd_pkg::*;

	// a non-special request completes in one cycle; a special waits for retire
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cpu.request_valid             <= 1'b0;
			cpu.request_phase_one_code    <= 5'h00;
			cpu.request_phase_two_code    <= 5'h00;
			cpu.first_address_phase_lines <= '0;
			cpu.byte_enable_lines         <= 8'h00;
			cpu.management_space_flag     <= 1'b0;
			busy_out                      <= 1'b0;
			done_out                      <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (!busy_out && issue_in) begin
				cpu.request_valid          <= 1'b1;
				cpu.request_phase_one_code <= issue_special_in ? REQ_ONE_SPECIAL : 5'h06; // [RQ1]
				cpu.request_phase_two_code <= issue_special_in ? {2'h0, REQ_TWO_SPECIAL} : 5'h00;
				cpu.byte_enable_lines      <= issue_type_in; // [RQ3]
				// junk on the first phase of specials proves the device ignores it
				cpu.first_address_phase_lines <= {ADDR_W{issue_special_in}}; // [RQ2]
				cpu.management_space_flag  <= issue_flag_in; // [RQ11] [RQ14]
				busy_out                   <= issue_special_in;
				done_out                   <= !issue_special_in;
			end else if (busy_out && cpu.request_retired) begin
				cpu.request_valid <= 1'b0;
				busy_out          <= 1'b0;
				done_out          <= 1'b1;
			end else if (!busy_out) begin
				cpu.request_valid <= 1'b0;
			end
		end
	end
endmodule

/* tb/hscd_sva.sv */
module hscd_sva
	import hscd_pkg::*;
(
	input logic       clock_in,
	input logic       reset_n_in,
	input logic       request_valid_in,
	input logic [4:0] request_phase_one_code_in,
	input logic [4:0] request_phase_two_code_in,
	input logic [7:0] byte_enable_lines_in,
	input logic       request_claimed_in,
	input logic       request_retired_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);
	logic spec;
	logic fwd;
	assign spec = request_phase_one_code_in == REQ_ONE_SPECIAL
		&& request_phase_two_code_in[2:0] == REQ_TWO_SPECIAL;
	assign fwd = byte_enable_lines_in inside {TYPE_SHUTDOWN, TYPE_HALT, TYPE_STOP_CLK_ACK};
	chk_claim_special: assert property (
		$rose(request_valid_in) && spec |=> request_claimed_in)
		else $error("special request not claimed");
	chk_plain_unclaimed: assert property (
		$rose(request_valid_in) && !spec |=> !request_claimed_in[*4])
		else $error("plain request claimed");
	// retire is registered from the next state, so it lands beside the claim
	chk_local_retire: assert property (
		$rose(request_valid_in) && spec && !fwd |-> ##1 request_retired_in)
		else $error("local type not retired on time");
	chk_fwd_held: assert property (
		$rose(request_valid_in) && spec && fwd |=> !request_retired_in[*2])
		else $error("forwarded type retired before abort");
	chk_fwd_bound: assert property (
		$rose(request_valid_in) && spec && fwd |-> ##[3:60] request_retired_in)
		else $error("forwarded type never retired");
	chk_claim_pulse: assert property (request_claimed_in |=> !request_claimed_in)
		else $error("claim longer than one cycle");
	chk_retire_pulse: assert property (request_retired_in |=> !request_retired_in)
		else $error("retire longer than one cycle");
	chk_retire_held: assert property (request_retired_in |-> request_valid_in)
		else $error("retire without pending request");
endmodule

/* tb/test_host_special_cycle_decoder.sv */
module test_host_special_cycle_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	import hscd_pkg::*;
	logic       clk = 1'b0, rst_n = 1'b0, iss = 1'b0, iss_sp = 1'b0, iss_fl = 1'b0, abort = 1'b0;
	logic [7:0] iss_ty = 8'h00;
	logic       busy, done, hub_v, open, acc, acc_seen = 1'b0;
	logic [1:0] hub_c, hub_seen;
	int         hcnt = 0, error_cnt = 0, samples_checked = 0;
	hscd_if hscd_if_i (.clock_in(clk), .reset_n_in(rst_n));
	hscd_device hscd_device_i (.clock_in(clk), .reset_n_in(rst_n), .cpu(hscd_if_i),
		.hub_cycle_valid_out(hub_v), .hub_cycle_code_out(hub_c), .hub_master_abort_in(abort),
		.mgmt_space_open_out(open), .mgmt_space_access_out(acc));
	hscd_processor hscd_processor_i (.clock_in(clk), .reset_n_in(rst_n), .cpu(hscd_if_i),
		.issue_in(iss), .issue_special_in(iss_sp), .issue_type_in(iss_ty),
		.issue_flag_in(iss_fl), .busy_out(busy), .done_out(done));
	hscd_sva hscd_sva_i (.clock_in(clk), .reset_n_in(rst_n),
		.request_valid_in(hscd_if_i.request_valid),
		.request_phase_one_code_in(hscd_if_i.request_phase_one_code),
		.request_phase_two_code_in(hscd_if_i.request_phase_two_code),
		.byte_enable_lines_in(hscd_if_i.byte_enable_lines),
		.request_claimed_in(hscd_if_i.request_claimed),
		.request_retired_in(hscd_if_i.request_retired));
	initial begin
		forever #10 clk = ~clk;
	end
	// hub end answers every forwarded cycle by master abort a few cycles late
	always @(posedge clk) begin
		if (hub_v === 1'b1)
			hub_seen <= hub_c;
		hcnt <= (hub_v === 1'b1) ? hcnt + 1 : 0;
		abort <= (hcnt == 3);
		if (acc === 1'b1)
			acc_seen <= 1'b1;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [7:0] ty, input logic fl);
		int n = 0;
		hub_seen = HUB_NONE;
		@(posedge clk);
		iss_sp <= 1'b1;
		iss_ty <= ty;
		iss_fl <= fl;
		iss <= 1'b1;
		@(posedge clk);
		iss <= 1'b0;
		@(negedge clk);
		cmp({7'h0, busy}, 8'h01);
		while (done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		cmp({7'h0, done}, 8'h01);
	endtask
	// one plain, non-special request; access flag checked eight cycles later
	task automatic plain(input logic fl);
		@(posedge clk);
		iss_sp <= 1'b0;
		iss_fl <= fl;
		iss <= 1'b1;
		@(posedge clk);
		iss <= 1'b0;
		repeat (8) @(negedge clk);
	endtask
	task automatic summarize();
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int t = 0; t < 10; t++) begin
			run((t == 9) ? 8'hff : t[7:0], 1'b0);
			cmp({6'h0, hub_seen}, {6'h0, t == 1 ? HUB_SHUTDOWN : t == 3 ? HUB_HALT :
				t == 6 ? HUB_STOP_GRANT : HUB_NONE});
			cmp({7'h0, open}, 8'h00);
		end
		run(TYPE_MGMT_ACK, 1'b1);
		cmp({7'h0, open}, 8'h01);
		cmp({6'h0, hub_seen}, {6'h0, HUB_NONE});
		plain(1'b0);
		cmp({7'h0, acc_seen}, 8'h00);
		run(TYPE_MGMT_ACK, 1'b0);
		cmp({7'h0, open}, 8'h00);
		plain(1'b1);
		cmp({7'h0, acc_seen}, 8'h00);
		run(TYPE_MGMT_ACK, 1'b1);
		cmp({7'h0, acc_seen}, 8'h00);
		plain(1'b1);
		cmp({7'h0, acc_seen}, 8'h01);
		summarize();
	end
endmodule
